/* File: common/sfr_pkg.sv */
// Purpose: shared constants and types for the serial flash read sequencer
// Assumes: byte wide array and buffer storage outside this block
// Notes:   page and column are kept apart so both page sizes share one path
package sfr_pkg;
    localparam logic [7:0]  OP_LP_READ    = 8'h01;
    localparam logic [7:0]  OP_PAGE_READ  = 8'hd2;
    localparam logic [7:0]  OP_BUF1_FAST  = 8'hd4;
    localparam logic [7:0]  OP_BUF1_SLOW  = 8'hd1;
    localparam logic [7:0]  OP_BUF2_FAST  = 8'hd6;
    localparam logic [7:0]  OP_BUF2_SLOW  = 8'hd3;
    localparam logic [7:0]  OP_DUAL_READ  = 8'h3b;
    localparam logic [4:0]  OP_LAST_BIT   = 5'h07;
    localparam logic [4:0]  ADDR_LAST_BIT = 5'h17;
    localparam logic [2:0]  DUMMY_PAGE    = 3'h4;
    localparam logic [2:0]  DUMMY_ONE     = 3'h1;
    localparam logic [2:0]  DUMMY_NONE    = 3'h0;
    localparam logic [9:0]  LAST_COL_528  = 10'h20f;
    localparam logic [9:0]  LAST_COL_512  = 10'h1ff;
    localparam int          PAGE_LSB_528  = 10;
    localparam int          PAGE_LSB_512  = 9;
    localparam logic [2:0]  SLOT_SINGLE   = 3'h7;
    localparam logic [2:0]  SLOT_DUAL     = 3'h3;
    localparam logic [2:0]  SYNC_RESET    = 3'h4;

    typedef enum logic [1:0] {
        SFR_SRC_ARRAY = 2'h0,
        SFR_SRC_BUF1  = 2'h1,
        SFR_SRC_BUF2  = 2'h2
    } sfr_src_t;

    typedef enum logic [1:0] {
        SFR_WRAP_ARRAY = 2'h0,
        SFR_WRAP_PAGE  = 2'h1,
        SFR_WRAP_BUF   = 2'h2
    } sfr_wrap_t;

    typedef struct packed {
        logic      known;
        sfr_src_t  src;
        sfr_wrap_t wrap;
        logic [2:0] dummy;
        logic      dual;
    } sfr_cmd_t;

    typedef struct packed {
        sfr_src_t    src;
        logic [12:0] page;
        logic [9:0]  col;
    } sfr_mreq_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR   = 3'b011,
        ST_DUMMY  = 3'b010,
        ST_DATA   = 3'b110,
        ST_IGNORE = 3'b111
    } sfr_state_t;
endpackage

/* File: rtl/sfr_sync.sv */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   only the second stage is visible outside
module sfr_sync #(
    parameter int              W         = 3,
    parameter logic [W-1:0]    RESET_VAL = '0
) (
    input  wire logic          ref_clk, // core clock
    input  wire logic          rst,     // synchronous reset
    input  wire logic [W-1:0]  d,       // asynchronous inputs
    output logic      [W-1:0]  q        // synchronised outputs
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_r <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

/* File: rtl/sfr_fifo.sv */
// Purpose: small flip-flop fifo between memory answers and the shifter
// Assumes: flush has priority over push and pop
// Notes:   in_ready is a register, so a full fifo stalls the memory port
module sfr_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic          ref_clk,   // core clock
    input  wire logic          rst,       // synchronous reset
    input  wire logic          flush,     // drop all contents
    input  wire logic          in_valid,  // push request
    output logic               in_ready,  // room for one word
    input  wire logic [W-1:0]  in_data,   // pushed word
    output logic               out_valid, // word available
    input  wire logic          out_ready, // pop request
    output logic      [W-1:0]  out_data   // head word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
        $error("sfr_fifo: depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   count_r;
    logic [AW:0]   count_nxt;
    logic          push;
    logic          pop;

    assign push      = in_valid && in_ready && !flush;
    assign out_valid = (count_r != '0);
    assign pop       = out_ready && out_valid && !flush;
    assign out_data  = mem_r[rd_ptr_r];
    assign count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr_r <= wr_ptr_r + AW'(push);
            rd_ptr_r <= rd_ptr_r + AW'(pop);
            count_r  <= count_nxt;
            in_ready <= (count_nxt < (AW + 1)'(DEPTH));
        end
    end
endmodule

/* File: rtl/sfr_read_seq.sv */
// Purpose: read command decoder and data shifter of a serial flash
// Assumes: spi mode 0 or 3, pins oversampled by ref_clk; memory answers in order
// Notes:   one memory request outstanding at a time; fifo hides memory latency

import sfr_pkg::*;

// Behaviour
// - 01h plus three address bytes, then data
// - 528 page: 13 page bits, 10 byte bits
// - 512 page: flat 22-bit byte address
// - array reads cross pages, wrap at end
// - chip select rise ends read, output released
// - reads never alter the sram buffers
// - D2h takes four dummy bytes before data
// - binary page read: 13 page, 9 byte bits
// - page read wraps within its page
// - D4h/D1h buffer one, D6h/D3h buffer two
// - 528 buffer: 14 ignored, 10 offset bits
// - 512 buffer: 15 ignored, 9 offset bits
// - buffer reads: one dummy byte only for D4h/D6h
// - buffer read wraps within that buffer
// - 3Bh, address, one dummy, then dual data
// - dual: bit7 upper, bit6 lower, four clocks
// - chip select rise releases both data lines
module sfr_read_seq #(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic              ref_clk,            // core clock
    input  wire logic              rst,                // synchronous reset
    input  wire logic              page_512,           // binary page size setting
    input  wire logic              cs_n,               // chip select pin
    input  wire logic              sck,                // serial clock pin
    input  wire logic              dual_lower_line_i,  // serial in / lower data line
    output logic                   dual_lower_line_o,  // lower data line drive
    output logic                   dual_lower_line_oe, // lower data line enable
    output logic                   dual_upper_line_o,  // serial out / upper data line
    output logic                   dual_upper_line_oe, // upper data line enable
    output logic                   mem_req_valid,      // memory read request
    output sfr_pkg::sfr_mreq_t     mem_req,            // source, page and column
    input  wire logic              mem_req_ready,      // request taken
    input  wire logic              mem_rsp_valid,      // read data valid
    input  wire logic [7:0]        mem_rsp_data,       // read data byte
    output logic                   mem_rsp_ready,      // room for read data
    output logic                   bad_opcode,         // last command not decoded
    output logic                   underrun            // shifter found fifo empty
);
    import sfr_pkg::*;

    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("sfr_read_seq: fifo depth below 2");
        end
    end

    function automatic sfr_cmd_t decode_op(input logic [7:0] op);
        sfr_cmd_t c;
        c       = '0;
        c.known = 1'b1;
        c.src   = SFR_SRC_ARRAY;
        c.wrap  = SFR_WRAP_ARRAY;
        c.dummy = DUMMY_NONE;
        c.dual  = 1'b0;
        unique case (op)
            OP_LP_READ: begin
                c.dummy = DUMMY_NONE;
            end
            OP_PAGE_READ: begin
                c.wrap  = SFR_WRAP_PAGE;
                c.dummy = DUMMY_PAGE;
            end
            OP_BUF1_FAST: begin
                c.src   = SFR_SRC_BUF1;
                c.wrap  = SFR_WRAP_BUF;
                c.dummy = DUMMY_ONE;
            end
            OP_BUF1_SLOW: begin
                c.src   = SFR_SRC_BUF1;
                c.wrap  = SFR_WRAP_BUF;
                c.dummy = DUMMY_NONE;
            end
            OP_BUF2_FAST: begin
                c.src   = SFR_SRC_BUF2;
                c.wrap  = SFR_WRAP_BUF;
                c.dummy = DUMMY_ONE;
            end
            OP_BUF2_SLOW: begin
                c.src   = SFR_SRC_BUF2;
                c.wrap  = SFR_WRAP_BUF;
                c.dummy = DUMMY_NONE;
            end
            OP_DUAL_READ: begin
                c.dummy = DUMMY_ONE;
                c.dual  = 1'b1;
            end
            default: begin
                c.known = 1'b0;
            end
        endcase
        return c;
    endfunction

    // split the received 24 address bits by command and page size
    function automatic sfr_mreq_t decode_addr(input logic [23:0] a, input sfr_cmd_t c,
                                              input logic p512);
        sfr_mreq_t m;
        m     = '0;
        m.src = c.src;
        if (c.wrap == SFR_WRAP_BUF) begin
            m.page = '0;
            m.col  = p512 ? {1'b0, a[8:0]} : a[9:0];
        end else if (p512) begin
            m.page = a[21:PAGE_LSB_512];
            m.col  = {1'b0, a[PAGE_LSB_512-1:0]};
        end else begin
            m.page = a[22:PAGE_LSB_528];
            m.col  = a[PAGE_LSB_528-1:0];
        end
        return m;
    endfunction

    function automatic sfr_mreq_t next_addr(input sfr_mreq_t m, input sfr_wrap_t w,
                                            input logic p512);
        sfr_mreq_t n;
        logic [9:0] last;
        n    = m;
        last = p512 ? LAST_COL_512 : LAST_COL_528;
        if (m.col != last) begin
            n.col = m.col + 10'h001;
        end else begin
            n.col = '0;
            if (w == SFR_WRAP_ARRAY) begin
                n.page = m.page + 13'h0001;
            end
        end
        return n;
    endfunction

    logic       cs_n_s;
    logic       sck_s;
    logic       si_s;
    logic       sck_prev_r;
    logic       sck_rise;
    logic       sck_fall;

    sfr_sync #(
        .W         (3),
        .RESET_VAL (SYNC_RESET)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       ({cs_n, sck, dual_lower_line_i}),
        .q       ({cs_n_s, sck_s, si_s})
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_s;
        end
    end

    assign sck_rise = sck_s && !sck_prev_r;
    assign sck_fall = !sck_s && sck_prev_r;

    sfr_state_t  state_r;
    sfr_cmd_t    cmd_r;
    sfr_cmd_t    op_dec;
    logic [4:0]  bit_cnt_r;
    logic [22:0] in_sh_r;
    logic [23:0] addr_in;
    logic        p512_r;
    logic        addr_done;
    logic [4:0]  dummy_last;

    assign op_dec     = decode_op({in_sh_r[6:0], si_s});
    assign addr_in    = {in_sh_r, si_s};
    assign addr_done  = (state_r == ST_ADDR) && sck_rise && (bit_cnt_r == ADDR_LAST_BIT);
    assign dummy_last = 5'({cmd_r.dummy, 3'h0} - 6'h01);

    // page size is frozen for the whole command
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            p512_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            p512_r <= page_512;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            in_sh_r <= '0;
        end else if (sck_rise) begin
            in_sh_r <= {in_sh_r[21:0], si_s};
        end
    end

    // command phases; a chip select rise returns to idle at once
    always_ff @(posedge ref_clk) begin
        if (rst || cs_n_s) begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= '0;
            cmd_r     <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    state_r   <= ST_OPCODE;
                    bit_cnt_r <= '0;
                end
                ST_OPCODE: begin
                    if (sck_rise) begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (bit_cnt_r == OP_LAST_BIT) begin
                            cmd_r     <= op_dec;
                            bit_cnt_r <= '0;
                            state_r   <= op_dec.known ? ST_ADDR : ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (addr_done) begin
                            bit_cnt_r <= '0;
                            state_r   <= (cmd_r.dummy == DUMMY_NONE) ? ST_DATA : ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sck_rise) begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (bit_cnt_r == dummy_last) begin
                            state_r <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    state_r <= ST_DATA;
                end
                ST_IGNORE: begin
                    state_r <= ST_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bad_opcode <= 1'b0;
        end else if (state_r == ST_OPCODE && sck_rise && bit_cnt_r == OP_LAST_BIT) begin
            bad_opcode <= !op_dec.known;
        end
    end

    // fetch side: one request in flight, refilling the fifo ahead of the shifter
    logic      active_r;
    logic      pend_r;
    logic      stale_r;
    logic      fifo_in_ready;
    logic      fifo_out_valid;
    logic      fifo_pop;
    logic [7:0] fifo_out_data;
    logic      rsp_hs;
    logic      req_hs;

    assign rsp_hs = mem_rsp_valid && mem_rsp_ready;
    assign req_hs = mem_req_valid && mem_req_ready;

    always_ff @(posedge ref_clk) begin
        if (rst || cs_n_s) begin
            active_r <= 1'b0;
        end else if (addr_done) begin
            active_r <= 1'b1;
        end
    end

    // requests carry only a read source and address; nothing is written back
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_req_valid <= 1'b0;
            mem_req       <= '0;
        end else if (addr_done && !mem_req_valid && !pend_r) begin
            mem_req <= decode_addr(addr_in, cmd_r, p512_r);
        end else if (req_hs) begin
            mem_req_valid <= 1'b0;
            mem_req       <= next_addr(mem_req, cmd_r.wrap, p512_r);
        end else if (active_r && !cs_n_s && !pend_r && fifo_in_ready) begin
            mem_req_valid <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else if (req_hs) begin
            pend_r <= 1'b1;
        end else if (rsp_hs) begin
            pend_r <= 1'b0;
        end
    end

    // an answer owed to an aborted command is thrown away
    always_ff @(posedge ref_clk) begin
        if (rst || rsp_hs) begin
            stale_r <= 1'b0;
        end else if (cs_n_s && (pend_r || mem_req_valid)) begin
            stale_r <= 1'b1;
        end
    end

    sfr_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .flush     (cs_n_s),
        .in_valid  (mem_rsp_valid && pend_r && !stale_r),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_rsp_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    assign mem_rsp_ready = fifo_in_ready;

    // shift side: drive on falling sck, msb first
    logic [7:0] tx_sh_r;
    logic [2:0] slot_r;
    logic       tx_edge;
    logic [7:0] load_byte;

    assign tx_edge   = (state_r == ST_DATA) && sck_fall;
    assign fifo_pop  = tx_edge && (slot_r == '0);
    assign load_byte = fifo_out_valid ? fifo_out_data : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (rst || cs_n_s) begin
            tx_sh_r           <= '0;
            slot_r            <= '0;
            dual_upper_line_o <= 1'b0;
            dual_lower_line_o <= 1'b0;
        end else if (tx_edge) begin
            if (slot_r == '0) begin
                dual_upper_line_o <= load_byte[7];
                dual_lower_line_o <= load_byte[6];
                tx_sh_r <= cmd_r.dual ? {load_byte[5:0], 2'b00} : {load_byte[6:0], 1'b0};
                slot_r  <= cmd_r.dual ? SLOT_DUAL : SLOT_SINGLE;
            end else begin
                dual_upper_line_o <= tx_sh_r[7];
                dual_lower_line_o <= tx_sh_r[6];
                tx_sh_r <= cmd_r.dual ? {tx_sh_r[5:0], 2'b00} : {tx_sh_r[6:0], 1'b0};
                slot_r  <= slot_r - 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || cs_n_s) begin
            dual_upper_line_oe <= 1'b0;
            dual_lower_line_oe <= 1'b0;
        end else if (tx_edge) begin
            dual_upper_line_oe <= 1'b1;
            dual_lower_line_oe <= cmd_r.dual;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || (state_r == ST_IDLE && !cs_n_s)) begin
            underrun <= 1'b0;
        end else if (fifo_pop && !fifo_out_valid) begin
            underrun <= 1'b1;
        end
    end
endmodule

/* File: testbench/sfr_read_seq_monitor.sv */
// Purpose: assertions on the read sequencer ports
// Assumes: memory port answers one request at a time
// Notes:   sequence checks are cleared whenever chip select is high
module sfr_read_seq_monitor (
    input wire logic               ref_clk,            // core clock
    input wire logic               rst,                // synchronous reset
    input wire logic               page_512,           // page size setting
    input wire logic               cs_n,               // chip select pin
    input wire logic               sck,                // serial clock pin
    input wire logic               dual_lower_line_i,  // serial in
    input wire logic               dual_lower_line_o,  // lower line value
    input wire logic               dual_lower_line_oe, // lower line enable
    input wire logic               dual_upper_line_o,  // upper line value
    input wire logic               dual_upper_line_oe, // upper line enable
    input wire logic               mem_req_valid,      // memory request
    input wire sfr_pkg::sfr_mreq_t mem_req,            // request fields
    input wire logic               mem_req_ready,      // request taken
    input wire logic               mem_rsp_valid,      // read data valid
    input wire logic [7:0]         mem_rsp_data,       // read data
    input wire logic               mem_rsp_ready,      // fifo room
    input wire logic               bad_opcode,         // refused opcode
    input wire logic               underrun            // fifo ran dry
);
    import sfr_pkg::*;
    logic       have_r;
    sfr_mreq_t  prev_r;
    logic [9:0] last_col;
    assign last_col = page_512 ? LAST_COL_512 : LAST_COL_528;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge ref_clk) begin
        if (rst || cs_n) have_r <= 1'b0;
        else if (mem_req_valid && mem_req_ready) have_r <= 1'b1;
    end
    always_ff @(posedge ref_clk) begin
        if (mem_req_valid && mem_req_ready) prev_r <= mem_req;
    end
    a_up_release: assert property (cs_n [*6] |-> !dual_upper_line_oe)
        else $error("serial out driven while deselected");
    a_lo_release: assert property (cs_n [*6] |-> !dual_lower_line_oe)
        else $error("lower line driven while deselected");
    a_lo_with_up: assert property ($rose(dual_lower_line_oe) |-> dual_upper_line_oe)
        else $error("lower line driven without upper line");
    a_oe_selected: assert property ($rose(dual_upper_line_oe) |-> !cs_n && !$past(cs_n, 4))
        else $error("output enabled outside a selected frame");
    a_col_528: assert property (mem_req_valid && !page_512 |-> mem_req.col <= LAST_COL_528)
        else $error("column beyond 528 byte page");
    a_col_512: assert property (mem_req_valid && page_512 |-> mem_req.col <= LAST_COL_512)
        else $error("column beyond 512 byte page");
    a_step_next: assert property ($rose(mem_req_valid) && have_r && prev_r.col != last_col
        |-> mem_req.col == prev_r.col + 10'h1 && mem_req.src == prev_r.src
        && (mem_req.src != SFR_SRC_ARRAY || mem_req.page == prev_r.page))
        else $error("next request not the following byte");
    a_wrap_zero: assert property ($rose(mem_req_valid) && have_r && prev_r.col == last_col
        |-> mem_req.col == 10'h0 && mem_req.src == prev_r.src)
        else $error("no wrap to column zero");
    a_bad_silent: assert property (bad_opcode |-> !dual_upper_line_oe && !dual_lower_line_oe)
        else $error("lines driven after refused opcode");
endmodule

bind sfr_read_seq sfr_read_seq_monitor u_mon (.*);

/* File: testbench/sfr_host_model.sv */
// Purpose: spi host driving frames into the read sequencer
// Assumes: mode 0, sck low between frames, 5 low and 4 high cycles per command bit, 6 low and 4 high per data bit
// Notes:   data sampled just before each rise; released lines read as z
module sfr_host_model (
    input  wire logic ref_clk, // core clock
    input  wire logic up_pin,  // upper line as seen
    input  wire logic lo_pin,  // lower line as seen
    output logic      cs_n,    // chip select
    output logic      sck,     // serial clock
    output logic      si       // serial in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic run(input logic [7:0] op, input logic [23:0] a, input int nd, input int n,
                       input bit dual, input int gap, output logic [7:0] got [$]);
        logic [63:0] cmd;
        logic [7:0]  b;
        got = {};
        cmd = {op, a, 32'h0};
        @(posedge ref_clk) cs_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 32 + 8 * nd; i++) begin
            sck <= 1'b0;
            si <= cmd[63 - i];
            repeat (5) @(posedge ref_clk);
            sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        repeat (40) @(posedge ref_clk);
        for (int k = 0; k < n; k++) begin
            for (int j = 0; j < (dual ? 4 : 8); j++) begin
                sck <= 1'b0;
                si <= ~si;
                repeat (6) @(posedge ref_clk);
                b = dual ? {b[5:0], up_pin, lo_pin} : {b[6:0], up_pin};
                sck <= 1'b1;
                repeat (4) @(posedge ref_clk);
            end
            got.push_back(b);
            repeat (gap) @(posedge ref_clk);
        end
        sck <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

/* File: testbench/sfr_read_seq_tb_top.sv */
// Purpose: self-checking bench for the read sequencer
// Assumes: memory model answers three cycles after a request
// Notes:   memory byte depends on source, page and column
module sfr_read_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sfr_pkg::*;
    logic       ref_clk, rst, page_512, cs_n, sck, si, lo_i, lo_o, lo_oe, up_o, up_oe;
    logic       rq_v, rq_rdy, rs_v, rs_rdy, bad, und, saw_full;
    logic [7:0] rs_d;
    logic [1:0] lat;
    sfr_mreq_t  rq;
    int         miscompares, checked;
    assign lo_i = lo_oe ? lo_o : si;
    sfr_host_model host (.ref_clk(ref_clk), .up_pin(up_oe ? up_o : 1'bz), .lo_pin(lo_oe ? lo_o : 1'bz),
                         .cs_n(cs_n), .sck(sck), .si(si));
    sfr_read_seq #(.FIFO_DEPTH(4)) dut (.ref_clk(ref_clk), .rst(rst), .page_512(page_512), .cs_n(cs_n),
        .sck(sck), .dual_lower_line_i(lo_i), .dual_lower_line_o(lo_o), .dual_lower_line_oe(lo_oe),
        .dual_upper_line_o(up_o), .dual_upper_line_oe(up_oe), .mem_req_valid(rq_v), .mem_req(rq),
        .mem_req_ready(rq_rdy), .mem_rsp_valid(rs_v), .mem_rsp_data(rs_d), .mem_rsp_ready(rs_rdy),
        .bad_opcode(bad), .underrun(und));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] mdat(sfr_mreq_t r);
        logic [12:0] p;
        p = (r.src == SFR_SRC_ARRAY) ? r.page : 13'h0;
        return r.col[7:0] ^ {p[2:0], 3'h0, r.col[9:8]} ^ {r.src, 6'h0};
    endfunction
    always @(posedge ref_clk) begin
        rq_rdy <= 1'b0;
        if (!rst && !rs_rdy) saw_full <= 1'b1;
        if (rst) begin
            rs_v <= 1'b0;
            lat <= 2'h0;
        end else if (rs_v) begin
            if (rs_rdy) begin
                rs_v <= 1'b0;
                rs_d <= ~rs_d;
            end
        end else if (lat != 2'h0) begin
            lat <= lat - 2'h1;
            rs_v <= (lat == 2'h1);
        end else if (rq_v && !rq_rdy) begin
            rq_rdy <= 1'b1;
            lat <= 2'h3;
            rs_d <= mdat(rq);
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nd, input sfr_src_t src,
                         input sfr_wrap_t wr, input int n, input int gap);
        logic [7:0] got [$];
        logic [9:0] last;
        sfr_mreq_t  r;
        last = page_512 ? 10'd511 : 10'd527;
        r.src = src;
        r.page = page_512 ? a[21:9] : a[22:10];
        r.col = page_512 ? {1'b0, a[8:0]} : a[9:0];
        host.run(op, a, nd, n, op == 8'h3b, gap, got);
        for (int k = 0; k < n; k++) begin
            check("read byte", got[k], mdat(r));
            if (r.col != last) r.col = r.col + 10'h1;
            else begin
                r.col = 10'h0;
                if (wr == SFR_WRAP_ARRAY) r.page = r.page + 13'h1;
            end
        end
        check("end status", {4'h0, bad, und, up_oe, lo_oe}, 8'h0);
    endtask
    task automatic t_low_power;
        page_512 <= 1'b0;
        @(posedge ref_clk);
        frame(8'h01, {1'b0, 13'd5, 10'd526}, 0, SFR_SRC_ARRAY, SFR_WRAP_ARRAY, 4, 0);
        page_512 <= 1'b1;
        @(posedge ref_clk);
        frame(8'h01, {2'b0, 13'h1fff, 9'd510}, 0, SFR_SRC_ARRAY, SFR_WRAP_ARRAY, 3, 0);
    endtask
    task automatic t_page_read;
        for (int p = 0; p < 2; p++) begin
            page_512 <= p[0];
            @(posedge ref_clk);
            frame(8'hd2, p ? {2'b0, 13'd9, 9'd510} : {1'b0, 13'd9, 10'd526}, 4,
                  SFR_SRC_ARRAY, SFR_WRAP_PAGE, 3, 0);
        end
    endtask
    task automatic t_buffers;
        logic [7:0] ops [4] = '{8'hd4, 8'hd1, 8'hd6, 8'hd3};
        for (int p = 0; p < 2; p++) begin
            page_512 <= p[0];
            @(posedge ref_clk);
            for (int i = 0; i < 4; i++) begin
                frame(ops[i], p ? {15'h7fff, 9'h1fe} : {14'h3fff, 10'h20e}, (i % 2 == 0) ? 1 : 0,
                      (i < 2) ? SFR_SRC_BUF1 : SFR_SRC_BUF2, SFR_WRAP_BUF, 3, 0);
            end
        end
    endtask
    task automatic t_dual;
        page_512 <= 1'b0;
        saw_full <= 1'b0;
        @(posedge ref_clk);
        frame(8'h3b, {1'b0, 13'd7, 10'd526}, 1, SFR_SRC_ARRAY, SFR_WRAP_ARRAY, 3, 60);
        check("fifo refused", {7'h0, saw_full}, 8'h1);
    endtask
    task automatic t_bad;
        logic [7:0] got [$];
        host.run(8'h55, 24'h0, 0, 1, 1'b0, 0, got);
        check("refused data", got[0], 8'hzz);
        check("refused flag", {7'h0, bad}, 8'h1);
    endtask
    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        miscompares = 0;
        checked = 0;
        rst = 1'b1;
        page_512 = 1'b0;
        saw_full = 1'b0;
        rq_rdy = 1'b0;
        rs_v = 1'b0;
        rs_d = 8'h0;
        lat = 2'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_low_power;
        t_page_read;
        t_buffers;
        t_dual;
        t_bad;
        wrap_up;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        wrap_up;
    end
endmodule
